// ===== rtl/scan_pkg.sv
// Function
// (RL1) integration equals start-to-hold interval minus 18 clocks
// (RL2) start and hold strobes driven as one
// (RL3) clocked high start pulse begins readout cycle
// (RL4) at least n+1 clocks between start pulses
// (RL5) start-to-start interval at most 100 ms
// (RL6) start holds all pixels, shows pixel 1
// (RL7) each clock advances output to next pixel
// (RL8) integrators reset for start plus 17 clocks
// (RL9) 19th clock releases reset, integration begins
// (RL10) first 18 pixels shift out during reset
// (RL11) pixels resume sampling after their readout clock
// (RL12) clock n+1 floats the analog output
// (RL13) wait 20 us after n+1 clocks
// (RL14) integration at least (n-18) clocks plus 20 us
// (RL15) sensor clock never faster than 8 MHz
// (RL16) flush first frame after power-up
// (RL17) park sensor clock low when idle
// (RL18) previous frame read out during next integration
// (RL19) pixel value valid for whole clock period
// (RL20) report saturation so integration can shorten
// (RL21) start drops before following rising edge
// (RL22) n is 640, or 1280 chained
package scan_pkg;
    localparam int PIXELS_SECTION = 640; // see (RL22)
    localparam int PIXELS_CHAINED = 1280;
    localparam int PIXEL_W = 8;
    localparam int EXPOSE_W = 24;
    localparam int SCALE_SHIFT = 8;
    localparam int SYNC_STAGES = 2;
    localparam int RESET_CLOCKS = 18;
    localparam int RELEASE_CLOCK = 19;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCLK_MAX_MHZ = 8;
    localparam int SCLK_MIN_PERIOD_NS = 1000 / SCLK_MAX_MHZ;
    localparam int SCLK_HALF_CYCLES =
        (SCLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    localparam int TRANSFER_US = 20;
    localparam int TRANSFER_CYCLES =
        (TRANSFER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MAX_PERIOD_MS = 100;
    localparam int MAX_PERIOD_CYCLES = MAX_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int WAIT_W = 23;
    typedef enum logic [2:0] {
        CTL_IDLE, CTL_SHIFT_LOW, CTL_SHIFT_HIGH, CTL_TRANSFER, CTL_EXTEND
    } ctl_state_type;
endpackage

// ===== rtl/scan_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface scan_link_if #(parameter int DATA_W = scan_pkg::PIXEL_W);
    logic sensor_clk;
    logic start_pulse;
    logic [DATA_W-1:0] analog_pixel_output;
    logic analog_pixel_oe_n;
    modport sensor (
        input sensor_clk,
        input start_pulse,
        output analog_pixel_output,
        output analog_pixel_oe_n
    );
    modport ctrl (
        output sensor_clk,
        output start_pulse,
        input analog_pixel_output,
        input analog_pixel_oe_n
    );
endinterface
`default_nettype wire

// ===== rtl/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pin,
    output logic level,
    output logic rise
);
    import scan_pkg::*;
    logic [SYNC_STAGES-1:0] sync_reg;
    logic [SYNC_STAGES-1:0] sync_next;
    logic last_reg;
    logic last_next;
    always_comb begin
        sync_next = {sync_reg[SYNC_STAGES-2:0], pin};
        last_next = sync_reg[SYNC_STAGES-1];
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_reg <= '0;
            last_reg <= 1'b0;
        end else begin
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end
    assign level = sync_reg[SYNC_STAGES-1];
    assign rise = sync_reg[SYNC_STAGES-1] & ~last_reg;
endmodule
`default_nettype wire

// ===== rtl/scan_sensor.sv
`timescale 1ns/100ps
`default_nettype none
module scan_sensor #(
    parameter int PIXELS = scan_pkg::PIXELS_SECTION,
    parameter int DATA_W = scan_pkg::PIXEL_W
) (
    input wire logic clk,
    input wire logic rstn,
    scan_link_if.sensor link,
    input wire logic light_wr,
    input wire logic [$clog2(PIXELS)-1:0] light_addr,
    input wire logic [DATA_W-1:0] light_data,
    output logic integrator_reset_switch,
    output logic [$clog2(PIXELS+2)-1:0] clock_number
);
    import scan_pkg::*;
    localparam int IDX_W = $clog2(PIXELS);
    localparam int CNT_W = $clog2(PIXELS + 2);
    localparam int PROD_W = DATA_W + EXPOSE_W;

    logic sclk_rise;
    logic si_level;
    logic [DATA_W-1:0] light_map [PIXELS];
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic rst_sw_reg, rst_sw_next;
    logic drive_reg, drive_next;
    logic [EXPOSE_W-1:0] expose_reg, expose_next;
    logic [EXPOSE_W-1:0] held_reg, held_next;
    logic [DATA_W-1:0] data_reg, data_next;
    logic [IDX_W-1:0] rd_idx;
    logic [EXPOSE_W-1:0] rd_exposure;
    logic [PROD_W-1:0] product;

    pin_sync u_sclk (
        .clk(clk),
        .rstn(rstn),
        .pin(link.sensor_clk),
        .level(),
        .rise(sclk_rise)
    );
    pin_sync u_start (
        .clk(clk),
        .rstn(rstn),
        .pin(link.start_pulse),
        .level(si_level),
        .rise()
    );

    // light pattern per pixel, loaded by the user side
    always_ff @(posedge clk) begin
        if (light_wr) begin
            light_map[light_addr] <= light_data;
        end
    end

    // one shared integrator stands for every pixel: all reset and release together
    always_comb begin
        cnt_next = cnt_reg;
        rst_sw_next = rst_sw_reg;
        drive_next = drive_reg;
        held_next = held_reg;
        data_next = data_reg;
        rd_idx = '0;
        rd_exposure = held_reg;
        expose_next = expose_reg;
        if (sclk_rise && si_level) begin
            cnt_next = CNT_W'(1); // see (RL3)
            held_next = expose_reg; // see (RL6) see (RL18)
            rd_exposure = expose_reg;
            rst_sw_next = 1'b1; // see (RL8)
            drive_next = 1'b1; // see (RL6)
        end else if (sclk_rise && cnt_reg != '0) begin
            cnt_next = cnt_reg + 1'b1; // see (RL7)
            rd_idx = IDX_W'(cnt_reg);
            if (cnt_reg == CNT_W'(RELEASE_CLOCK - 1)) begin
                rst_sw_next = 1'b0; // see (RL9) see (RL11)
            end
            if (cnt_reg == CNT_W'(PIXELS)) begin
                drive_next = 1'b0; // see (RL12)
                cnt_next = '0;
            end
        end
        // counting starts on the releasing edge, so the span is start-to-start less setup
        if (rst_sw_next) begin
            expose_next = '0; // see (RL8)
        end else if (expose_reg != '1) begin
            expose_next = expose_reg + 1'b1; // see (RL1)
        end
        product = PROD_W'(light_map[rd_idx]) * PROD_W'(rd_exposure);
        // the last rise only floats the output: keep the held value defined
        if (sclk_rise && (si_level || (cnt_reg != '0 && cnt_reg != CNT_W'(PIXELS)))) begin
            // shifting continues while integrators are still in reset
            if (|(product >> (SCALE_SHIFT + DATA_W))) begin // see (RL10)
                data_next = '1;
            end else begin
                data_next = DATA_W'(product >> SCALE_SHIFT);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= '0;
            rst_sw_reg <= 1'b0;
            drive_reg <= 1'b0;
            expose_reg <= '0;
            held_reg <= '0;
            data_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            rst_sw_reg <= rst_sw_next;
            drive_reg <= drive_next;
            expose_reg <= expose_next;
            held_reg <= held_next;
            data_reg <= data_next;
        end
    end

    // value stands until the next sensor clock rising edge
    assign link.analog_pixel_output = data_reg; // see (RL19)
    assign link.analog_pixel_oe_n = ~drive_reg;
    assign integrator_reset_switch = rst_sw_reg;
    assign clock_number = cnt_reg;
endmodule
`default_nettype wire

// ===== rtl/scan_controller.sv
`timescale 1ns/100ps
`default_nettype none
module scan_controller #(
    parameter int PIXELS = scan_pkg::PIXELS_SECTION,
    parameter int DATA_W = scan_pkg::PIXEL_W,
    parameter int MAX_PERIOD_CYCLES = scan_pkg::MAX_PERIOD_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    scan_link_if.ctrl link,
    input wire logic run,
    input wire logic [scan_pkg::WAIT_W-1:0] extra_wait,
    output logic [DATA_W-1:0] pixel_data,
    output logic [$clog2(PIXELS)-1:0] pixel_index,
    output logic pixel_valid,
    output logic frame_done,
    output logic saturated,
    output logic float_fault,
    output logic busy,
    output logic [scan_pkg::WAIT_W-1:0] integration_cycles
);
    import scan_pkg::*;
    localparam int IDX_W = $clog2(PIXELS);
    localparam int CNT_W = $clog2(PIXELS + 2);
    localparam int HALF_W = $clog2(SCLK_HALF_CYCLES + 1);
    localparam int SETUP_CYCLES = RESET_CLOCKS * 2 * SCLK_HALF_CYCLES;

    ctl_state_type state_reg, state_next;
    logic [HALF_W-1:0] half_reg, half_next;
    logic [CNT_W-1:0] edge_reg, edge_next;
    logic [WAIT_W-1:0] wait_reg, wait_next;
    logic [WAIT_W-1:0] period_reg, period_next;
    logic sclk_reg, sclk_next;
    logic si_reg, si_next;
    logic flush_reg, flush_next;
    logic first_reg, first_next;
    logic [DATA_W-1:0] data_reg, data_next;
    logic [IDX_W-1:0] index_reg, index_next;
    logic valid_reg, valid_next;
    logic done_reg, done_next;
    logic sat_reg, sat_next;
    logic float_reg, float_next;
    logic [WAIT_W-1:0] int_reg, int_next;
    logic half_end;
    logic period_cap;

    assign half_end = (half_reg == HALF_W'(SCLK_HALF_CYCLES - 1));
    // leave room for the low half that precedes the next start edge
    assign period_cap = (period_reg >= WAIT_W'(MAX_PERIOD_CYCLES - SCLK_HALF_CYCLES));

    always_comb begin
        state_next = state_reg;
        half_next = half_reg;
        edge_next = edge_reg;
        wait_next = wait_reg;
        sclk_next = sclk_reg;
        si_next = si_reg;
        flush_next = flush_reg;
        first_next = first_reg;
        data_next = data_reg;
        index_next = index_reg;
        valid_next = 1'b0;
        done_next = 1'b0;
        sat_next = sat_reg;
        float_next = float_reg;
        int_next = int_reg;
        period_next = period_reg;
        if (period_reg != '1) begin
            period_next = period_reg + 1'b1;
        end
        unique case (state_reg)
            CTL_IDLE: begin
                sclk_next = 1'b0; // see (RL17)
                si_next = 1'b0;
                if (run) begin
                    state_next = CTL_SHIFT_LOW;
                    half_next = '0;
                    edge_next = '0;
                    si_next = 1'b1; // see (RL2)
                end
            end
            CTL_SHIFT_LOW: begin
                half_next = half_reg + 1'b1;
                if (half_end) begin
                    half_next = '0;
                    sclk_next = 1'b1; // see (RL15)
                    edge_next = edge_reg + 1'b1;
                    state_next = CTL_SHIFT_HIGH;
                    if (edge_reg == '0) begin
                        // start edge: measure the integration just ended
                        period_next = WAIT_W'(1);
                        sat_next = 1'b0;
                        if (!first_reg) begin
                            int_next = period_reg - WAIT_W'(SETUP_CYCLES); // see (RL1)
                        end
                        first_next = 1'b0;
                    end else begin
                        // sampled at the end of the period, value long settled
                        data_next = link.analog_pixel_output; // see (RL19)
                        index_next = IDX_W'(edge_reg - 1'b1);
                        valid_next = ~flush_reg; // see (RL16) see (RL18)
                        if (link.analog_pixel_output == '1) begin
                            sat_next = 1'b1; // see (RL20)
                        end
                        if (link.analog_pixel_oe_n) begin
                            float_next = 1'b1;
                        end
                    end
                end
            end
            CTL_SHIFT_HIGH: begin
                half_next = half_reg + 1'b1;
                if (half_end) begin
                    half_next = '0;
                    sclk_next = 1'b0;
                    si_next = 1'b0; // see (RL21)
                    if (edge_reg == CNT_W'(PIXELS + 1)) begin
                        state_next = CTL_TRANSFER; // see (RL4)
                        wait_next = '0;
                    end else begin
                        state_next = CTL_SHIFT_LOW;
                    end
                end
            end
            CTL_TRANSFER: begin
                // last pixel needs time to charge its sampling capacitor
                wait_next = wait_reg + 1'b1;
                if (wait_reg == WAIT_W'(TRANSFER_CYCLES - 1)) begin // see (RL13) see (RL14)
                    wait_next = '0;
                    state_next = CTL_EXTEND;
                    if (!link.analog_pixel_oe_n) begin
                        float_next = 1'b1; // see (RL12)
                    end
                end
            end
            CTL_EXTEND: begin
                wait_next = wait_reg + 1'b1;
                if (wait_reg >= extra_wait || period_cap) begin // see (RL5)
                    done_next = 1'b1;
                    flush_next = 1'b0; // see (RL16)
                    wait_next = '0;
                    if (run) begin
                        state_next = CTL_SHIFT_LOW;
                        half_next = '0;
                        edge_next = '0;
                        si_next = 1'b1; // see (RL3)
                    end else begin
                        state_next = CTL_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= CTL_IDLE;
            half_reg <= '0;
            edge_reg <= '0;
            wait_reg <= '0;
            period_reg <= '0;
            sclk_reg <= 1'b0;
            si_reg <= 1'b0;
            flush_reg <= 1'b1;
            first_reg <= 1'b1;
            data_reg <= '0;
            index_reg <= '0;
            valid_reg <= 1'b0;
            done_reg <= 1'b0;
            sat_reg <= 1'b0;
            float_reg <= 1'b0;
            int_reg <= '0;
        end else begin
            state_reg <= state_next;
            half_reg <= half_next;
            edge_reg <= edge_next;
            wait_reg <= wait_next;
            period_reg <= period_next;
            sclk_reg <= sclk_next;
            si_reg <= si_next;
            flush_reg <= flush_next;
            first_reg <= first_next;
            data_reg <= data_next;
            index_reg <= index_next;
            valid_reg <= valid_next;
            done_reg <= done_next;
            sat_reg <= sat_next;
            float_reg <= float_next;
            int_reg <= int_next;
        end
    end

    // one wire carries both the start and the hold strobe
    assign link.sensor_clk = sclk_reg;
    assign link.start_pulse = si_reg; // see (RL2)
    assign pixel_data = data_reg;
    assign pixel_index = index_reg;
    assign pixel_valid = valid_reg;
    assign frame_done = done_reg;
    assign saturated = sat_reg;
    assign float_fault = float_reg;
    assign busy = (state_reg != CTL_IDLE);
    assign integration_cycles = int_reg;
endmodule
`default_nettype wire

// ===== bench/scan_link_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module scan_link_assertions
    import scan_pkg::*;
#(
    parameter int PIXELS = scan_pkg::PIXELS_SECTION,
    parameter int DATA_W = scan_pkg::PIXEL_W,
    parameter int MAX_PERIOD_CYCLES = scan_pkg::MAX_PERIOD_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sensor_clk,
    input wire logic start_pulse,
    input wire logic [DATA_W-1:0] analog_pixel_output,
    input wire logic analog_pixel_oe_n
);
    logic sclk_d_reg, sclk_d_next, start_d_reg, start_d_next;
    logic [15:0] rise_cnt_reg, rise_cnt_next, low_cnt_reg, low_cnt_next;
    logic [31:0] period_cnt_reg, period_cnt_next;
    // rise count stays at PIXELS+1 until the next start, so spacing can be judged
    always_comb begin
        sclk_d_next = sensor_clk;
        start_d_next = start_pulse;
        rise_cnt_next = rise_cnt_reg;
        if (sensor_clk && !sclk_d_reg && start_pulse) begin
            rise_cnt_next = 16'h0001;
        end else if (sensor_clk && !sclk_d_reg && rise_cnt_reg != 16'h0000
                && rise_cnt_reg <= 16'(PIXELS)) begin
            rise_cnt_next = rise_cnt_reg + 16'h0001;
        end
        low_cnt_next = low_cnt_reg + {15'h0000, low_cnt_reg != 16'hFFFF};
        if (sensor_clk) begin
            low_cnt_next = 16'h0000;
        end
        period_cnt_next = period_cnt_reg + 32'h1;
        if (start_pulse && !start_d_reg) begin
            period_cnt_next = 32'h0;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_d_reg <= 1'b0;
            start_d_reg <= 1'b0;
            rise_cnt_reg <= 16'h0000;
            low_cnt_reg <= 16'h0000;
            period_cnt_reg <= 32'h0;
        end else begin
            sclk_d_reg <= sclk_d_next;
            start_d_reg <= start_d_next;
            rise_cnt_reg <= rise_cnt_next;
            low_cnt_reg <= low_cnt_next;
            period_cnt_reg <= period_cnt_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_strobe;
        start_pulse [*8] ##1 !start_pulse;
    endsequence
    sequence s_high_half;
        sensor_clk [*4] ##1 !sensor_clk;
    endsequence
    sequence s_start_edge;
        $rose(start_pulse) ##4 $rose(sensor_clk);
    endsequence
    property p_strobe;
        $rose(start_pulse) |-> s_strobe;
    endproperty
    a_strobe: assert property (p_strobe) else $error("start strobe width wrong");
    property p_half;
        $rose(sensor_clk) |-> s_high_half;
    endproperty
    a_half: assert property (p_half) else $error("sensor clock high too short");
    property p_park;
        $rose(start_pulse) |-> !sensor_clk;
    endproperty
    a_park: assert property (p_park) else $error("start raised with clock high");
    property p_lead;
        $rose(start_pulse) |-> ##4 $rose(sensor_clk);
    endproperty
    a_lead: assert property (p_lead) else $error("start not sampled by a rise");
    property p_show;
        s_start_edge |=> ##[2:4] !analog_pixel_oe_n;
    endproperty
    a_show: assert property (p_show) else $error("first pixel not driven");
    property p_next;
        $rose(sensor_clk) && rise_cnt_reg inside {[1:PIXELS-1]} |-> !analog_pixel_oe_n [*8];
    endproperty
    a_next: assert property (p_next) else $error("output floated mid frame");
    property p_hold;
        $rose(sensor_clk) && rise_cnt_reg != 16'(PIXELS)
            |-> ##6 $stable(analog_pixel_output) [*5];
    endproperty
    a_hold: assert property (p_hold) else $error("pixel value moved in period");
    property p_float;
        $rose(sensor_clk) && rise_cnt_reg == 16'(PIXELS) |-> ##[3:5] analog_pixel_oe_n;
    endproperty
    a_float: assert property (p_float) else $error("output not floated");
    property p_spacing;
        $rose(start_pulse) |-> rise_cnt_reg == 16'h0000 || (rise_cnt_reg == 16'(PIXELS + 1)
            && low_cnt_reg >= 16'(TRANSFER_CYCLES));
    endproperty
    a_spacing: assert property (p_spacing) else $error("start too early");
    property p_cap;
        $rose(start_pulse) |-> period_cnt_reg < 32'(MAX_PERIOD_CYCLES);
    endproperty
    a_cap: assert property (p_cap) else $error("start period too long");
endmodule
`default_nettype wire

// ===== bench/test_linear_array_scan_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module test_linear_array_scan_sequencer;
    import scan_pkg::*;
    localparam int PIX = 24;
    localparam int MAXP = 6000;
    logic clk, rstn, run, light_wr, pixel_valid, frame_done, saturated, float_fault, busy;
    logic integrator_reset_switch;
    logic sat_exp = 1'b0;
    logic start_d = 1'b0;
    logic [WAIT_W-1:0] extra_wait, integration_cycles;
    logic [4:0] light_addr, pixel_index, clock_number;
    logic [PIXEL_W-1:0] light_data, pixel_data;
    int error_cnt, tests_run, cyc, t_start, nstart, idx_exp, e_exp, v;
    scan_link_if #(.DATA_W(PIXEL_W)) link();
    scan_sensor #(.PIXELS(PIX), .DATA_W(PIXEL_W)) scan_sensor_inst (.clk(clk), .rstn(rstn),
        .link(link), .light_wr(light_wr), .light_addr(light_addr), .light_data(light_data),
        .integrator_reset_switch(integrator_reset_switch), .clock_number(clock_number));
    scan_controller #(.PIXELS(PIX), .DATA_W(PIXEL_W), .MAX_PERIOD_CYCLES(MAXP))
        scan_controller_inst (.clk(clk), .rstn(rstn), .link(link), .run(run),
        .extra_wait(extra_wait), .pixel_data(pixel_data), .pixel_index(pixel_index),
        .pixel_valid(pixel_valid), .frame_done(frame_done), .saturated(saturated),
        .float_fault(float_fault), .busy(busy), .integration_cycles(integration_cycles));
    scan_link_assertions #(.PIXELS(PIX), .DATA_W(PIXEL_W), .MAX_PERIOD_CYCLES(MAXP))
        scan_link_assertions_inst (.clk(clk), .rstn(rstn), .sensor_clk(link.sensor_clk),
        .start_pulse(link.start_pulse), .analog_pixel_output(link.analog_pixel_output),
        .analog_pixel_oe_n(link.analog_pixel_oe_n));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wait_frames(input int n);
        int k;
        repeat (n) begin
            k = 0;
            @(negedge clk);
            while (frame_done !== 1'b1 && k < 8000) begin
                @(negedge clk);
                k++;
            end
            chk("frame wait", 0, k >= 8000);
        end
    endtask
    // light of pixel i is i+1, so every expected value is worked out from the wire
    always @(negedge clk) begin
        cyc++;
        // judged before a start in the same cycle moves the frame counters on
        if (frame_done === 1'b1) begin
            chk("pixel count", nstart > 1 ? PIX : 0, idx_exp);
            if (nstart > 1) begin
                chk("integration", e_exp, integration_cycles);
                chk("saturated", sat_exp, saturated);
                chk("min integration", 1, integration_cycles >=
                    (PIX - RESET_CLOCKS) * 2 * SCLK_HALF_CYCLES + TRANSFER_CYCLES);
            end
            chk("float fault", 0, float_fault);
            idx_exp = 0;
            sat_exp = 1'b0;
        end
        if (link.start_pulse === 1'b1 && !start_d) begin
            if (nstart > 0) begin
                e_exp = cyc - t_start - 18 * 8;
                chk("start period", 1, cyc - t_start <= MAXP);
            end
            t_start = cyc;
            nstart++;
        end
        start_d = link.start_pulse;
        if (clock_number != 0) begin
            chk("reset switch", clock_number < 19, integrator_reset_switch);
        end
        if (pixel_valid === 1'b1) begin
            v = (idx_exp + 1) * e_exp / 256;
            sat_exp = sat_exp | (v >= 255);
            chk("pixel index", idx_exp, pixel_index);
            chk("pixel data", v > 255 ? 255 : v, pixel_data);
            idx_exp++;
        end
    end
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // a capped frame lasts 6000 cycles; the whole run needs about 30000
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        end_sim();
    end
    initial begin
        rstn = 1'b0;
        run = 1'b0;
        light_wr = 1'b0;
        light_addr = 5'h00;
        light_data = 8'h00;
        extra_wait = '0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < PIX; i++) begin
            @(posedge clk);
            light_wr <= 1'b1;
            light_addr <= 5'(i);
            light_data <= 8'(i + 1);
        end
        @(posedge clk);
        light_wr <= 1'b0;
        run <= 1'b1;
        wait_frames(3);
        @(posedge clk);
        extra_wait <= 23'h000BB8;
        wait_frames(2);
        @(posedge clk);
        extra_wait <= 23'h004E20;
        wait_frames(2);
        @(posedge clk);
        run <= 1'b0;
        wait_frames(1);
        repeat (20) @(negedge clk);
        chk("busy", 0, busy);
        chk("output float", 1, link.analog_pixel_oe_n);
        chk("clock parked", 0, link.sensor_clk);
        end_sim();
    end
endmodule
`default_nettype wire
